// ==== src/fdlc_config.v ====
// configuration, strap sampling, loopback override and yellow interrupt logic
`timescale 1ns/1ps
`include "fdlc_defs.vh"

module fdlc_config #(
  parameter [24:0] PROG_HOLD_CYC = `FDLC_PROG_HOLD_CYC
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire user_strap_one_i,
  input wire user_strap_two_i,
  input wire user_strap_three_i,
  input wire user_strap_four_i,
  input wire user_strap_five_i,
  input wire user_strap_six_i,
  input wire line_code_strap_i,
  input wire prog_addr_sel_i,
  input wire [4:0] nv_addr_i,
  input wire reg_wr_i,
  input wire [1:0] reg_sel_i,
  input wire [7:0] reg_wdata_i,
  input wire rx_addr_vld_i,
  input wire [4:0] rx_addr_i,
  input wire line_tick_i,
  input wire auto_line_loop_i,
  input wire auto_payload_loop_i,
  input wire slip_b_i,
  input wire yellow_req_i,
  input wire report_due_i,
  input wire unsched_msg_i,
  input wire tx_byte_done_i,
  input wire msg_done_i,
  output reg nv_wr_o,
  output reg [4:0] nv_wdata_o,
  output reg [4:0] station_addr_o,
  output reg addr_hit_o,
  output reg extra_bit_off_o,
  output reg [7:0] loopback_control_o,
  output reg [7:0] station_control_o,
  output reg [7:0] strap_config_o,
  output reg [7:0] report_config_o,
  output reg hw_mode_o,
  output reg auto_run_o,
  output reg [7:0] idle_code_o,
  output reg line_loopback_out_o,
  output reg payload_loopback_out_o,
  output reg slip_ind_o,
  output reg enh_cfg_resp_ok_o,
  output reg tx_yellow_o,
  output reg tx_flag_o,
  output reg tx_report_o,
  output reg tx_unsched_o
);

  // idle passes yellow through when asked; flags and msg carry the interrupt
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_FLAGS = 2'h1;
  localparam [1:0] ST_MSG = 2'h2;

  // forced value when override set, else the automatic source
  function sel_loop;
    input ovr;
    input frc;
    input auto;
    begin
      sel_loop = ovr ? frc : auto;
    end
  endfunction

  reg sampled_q;
  reg prog_q;
  // wide enough to count one second of the core clock
  reg [24:0] hold_q;
  reg [4:0] addr_q;
  reg [7:0] loopback_control_q;
  reg [7:0] loopback_control_d;
  reg [7:0] stc_q;
  reg [7:0] scr_q;
  reg [7:0] rcr_q;
  reg hw_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [4:0] flag_cnt_q;
  reg [4:0] flag_cnt_d;
  reg unsched_q;
  reg unsched_d;

  wire [4:0] strap_addr;
  wire ansi_mode;
  wire prog_done;

  assign strap_addr = {user_strap_five_i, user_strap_four_i, user_strap_three_i,
                       user_strap_two_i, user_strap_one_i};
  assign ansi_mode = ~scr_q[`FDLC_SC_CARRIER];
  assign prog_done = prog_q && (hold_q == PROG_HOLD_CYC - 25'h1);

  // straps are caught on the first edge after reset release; straps one to five again when programming ends
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sampled_q <= 1'b0;
      prog_q <= 1'b0;
      hold_q <= 25'h0;
      addr_q <= `FDLC_ADDR_DEFAULT;
      nv_wr_o <= 1'b0;
      nv_wdata_o <= `FDLC_ADDR_DEFAULT;
      hw_q <= 1'b0;
    end else begin
      // the store write strobe lasts a single cycle
      nv_wr_o <= 1'b0;
      if (!sampled_q) begin
        sampled_q <= 1'b1;
        hw_q <= ~user_strap_five_i;
        prog_q <= prog_addr_sel_i;
        hold_q <= 25'h0;
        // the store is read only here; programming loads a new address into addr_q directly, without a reset
        addr_q <= nv_addr_i;
      end else if (prog_q) begin
        // the store is written once, only after power has stood for the hold time
        if (prog_done) begin
          prog_q <= 1'b0;
          nv_wr_o <= 1'b1;
          nv_wdata_o <= strap_addr;
          addr_q <= strap_addr;
        end else begin
          hold_q <= hold_q + 25'h1;
        end
      end
    end
  end

  // bits 7 and 4 are reserved and always read back as zero
  always @* begin
    loopback_control_d = loopback_control_q;
    if (reg_wr_i && (reg_sel_i == `FDLC_SEL_LOOP)) begin
      loopback_control_d = reg_wdata_i & `FDLC_LOOP_MASK;
    end
  end

  // configuration registers: reset sample first, software may override later
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      loopback_control_q <= `FDLC_LOOP_RESET;
      stc_q <= 8'h00;
      scr_q <= 8'h00;
      rcr_q <= 8'h00;
    end else begin
      loopback_control_q <= loopback_control_d;
      if (!sampled_q) begin
        stc_q <= 8'h00;
        stc_q[`FDLC_ST_ALT] <= ~user_strap_one_i;
        stc_q[`FDLC_ST_IDLE] <= ~user_strap_two_i;
        scr_q <= 8'h00;
        scr_q[`FDLC_SC_B8ZS] <= line_code_strap_i;
        scr_q[`FDLC_SC_CARRIER] <= user_strap_four_i;
        scr_q[`FDLC_SC_SIX] <= user_strap_six_i;
        rcr_q <= 8'h00;
        rcr_q[`FDLC_RC_RXCR] <= ~user_strap_one_i;
        rcr_q[`FDLC_RC_TXCR] <= ~user_strap_two_i;
      // a station, strap or report write in the sampling cycle is lost: the straps win there
      end else if (reg_wr_i) begin
        case (reg_sel_i)
          `FDLC_SEL_STATION: stc_q <= reg_wdata_i & 8'h03;
          `FDLC_SEL_STRAP: scr_q <= reg_wdata_i & 8'h07;
          `FDLC_SEL_REPORT: rcr_q <= reg_wdata_i & 8'h03;
          default: ;
        endcase
      end
    end
  end

  // yellow alarm interrupt sequencer
  always @* begin
    state_d = state_q;
    flag_cnt_d = flag_cnt_q;
    unsched_d = unsched_q;
    case (state_q)
      ST_IDLE: begin
        // unscheduled traffic can start the interrupt only in ansi mode
        if (yellow_req_i && loopback_control_q[`FDLC_LB_YIE] &&
            (report_due_i || (ansi_mode && unsched_msg_i))) begin
          state_d = ST_FLAGS;
          flag_cnt_d = 5'h00;
          unsched_d = ansi_mode && unsched_msg_i;
        end
      end
      ST_FLAGS: begin
        if (tx_byte_done_i) begin
          flag_cnt_d = flag_cnt_q + 5'h01;
          if (flag_cnt_q == `FDLC_OPEN_FLAGS - 5'h01) begin
            state_d = ST_MSG;
          end
        end
      end
      ST_MSG: begin
        if (msg_done_i) begin
          state_d = ST_IDLE;
          unsched_d = 1'b0;
        end
      end
      default: begin
        state_d = ST_IDLE;
        unsched_d = 1'b0;
      end
    endcase
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
      flag_cnt_q <= 5'h00;
      unsched_q <= 1'b0;
      tx_yellow_o <= 1'b0;
      tx_flag_o <= 1'b0;
      tx_report_o <= 1'b0;
      tx_unsched_o <= 1'b0;
    end else begin
      state_q <= state_d;
      flag_cnt_q <= flag_cnt_d;
      unsched_q <= unsched_d;
      // taken from the next state so the levels line up with state_q
      tx_yellow_o <= yellow_req_i && (state_d == ST_IDLE);
      tx_flag_o <= state_d == ST_FLAGS;
      tx_report_o <= (state_d == ST_MSG) && !unsched_d;
      tx_unsched_o <= (state_d == ST_MSG) && unsched_d;
    end
  end

  // loopback pins and slip path move only on line-derived ticks
  // a write between ticks waits for the next tick, so pins never move mid-frame
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_loopback_out_o <= 1'b0;
      payload_loopback_out_o <= 1'b0;
      slip_ind_o <= 1'b0;
    end else if (line_tick_i) begin
      line_loopback_out_o <= sel_loop(loopback_control_q[`FDLC_LB_LOVR], loopback_control_q[`FDLC_LB_LFRC],
                                      auto_line_loop_i);
      payload_loopback_out_o <= sel_loop(loopback_control_q[`FDLC_LB_POVR], loopback_control_q[`FDLC_LB_PFRC],
                                         auto_payload_loop_i);
      slip_ind_o <= ~slip_b_i & ~loopback_control_q[`FDLC_LB_SLIP];
    end
  end

  // status and decode outputs, all registered
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      station_addr_o <= `FDLC_ADDR_DEFAULT;
      addr_hit_o <= 1'b0;
      extra_bit_off_o <= 1'b0;
      loopback_control_o <= `FDLC_LOOP_RESET;
      station_control_o <= 8'h00;
      strap_config_o <= 8'h00;
      report_config_o <= 8'h00;
      hw_mode_o <= 1'b0;
      auto_run_o <= 1'b0;
      idle_code_o <= `FDLC_IDLE_ONES;
      enh_cfg_resp_ok_o <= 1'b0;
    end else begin
      // readback registers lag their live copies by one cycle
      station_addr_o <= addr_q;
      // address 31 is a mode, not a station, so it never matches
      addr_hit_o <= rx_addr_vld_i && (addr_q <= `FDLC_ADDR_MAX) &&
                    (rx_addr_i == addr_q);
      extra_bit_off_o <= addr_q == `FDLC_ADDR_NO_XBIT;
      loopback_control_o <= loopback_control_q;
      station_control_o <= stc_q;
      strap_config_o <= scr_q;
      report_config_o <= rcr_q;
      hw_mode_o <= hw_q;
      // programming keeps the block off the link until the store is written
      auto_run_o <= sampled_q && !prog_q;
      idle_code_o <= stc_q[`FDLC_ST_IDLE] ? `FDLC_IDLE_FLAG : `FDLC_IDLE_ONES;
      // the model 3 response is only allowed while local slips are hidden
      enh_cfg_resp_ok_o <= !ansi_mode && loopback_control_q[`FDLC_LB_SLIP];
    end
  end

endmodule

// ==== src/fdlc_defs.vh ====
// constants for the facility data link configuration and loopback block
`ifndef FDLC_DEFS_VH
`define FDLC_DEFS_VH

`define FDLC_CLK_HZ 20000000
`define FDLC_PROG_HOLD_S 1
`define FDLC_PROG_HOLD_CYC 25'd20000000

`define FDLC_ADDR_DEFAULT 5'h00
`define FDLC_ADDR_MAX 5'h1e
`define FDLC_ADDR_NO_XBIT 5'h1f

`define FDLC_SEL_LOOP 2'h0
`define FDLC_SEL_STATION 2'h1
`define FDLC_SEL_STRAP 2'h2
`define FDLC_SEL_REPORT 2'h3

`define FDLC_LOOP_RESET 8'h00
`define FDLC_LOOP_MASK 8'h6f
`define FDLC_LB_SLIP 6
`define FDLC_LB_YIE 5
`define FDLC_LB_LOVR 3
`define FDLC_LB_LFRC 2
`define FDLC_LB_POVR 1
`define FDLC_LB_PFRC 0

`define FDLC_ST_ALT 0
`define FDLC_ST_IDLE 1
`define FDLC_SC_B8ZS 0
`define FDLC_SC_CARRIER 1
`define FDLC_SC_SIX 2
`define FDLC_RC_RXCR 0
`define FDLC_RC_TXCR 1

`define FDLC_IDLE_ONES 8'hff
`define FDLC_IDLE_FLAG 8'h7e
`define FDLC_OPEN_FLAGS 5'h1b

`endif

// ==== verification/fdlc_config_monitor.sv ====
// port assertions for the configuration and loopback block
`timescale 1ns/1ps
module fdlc_config_monitor (
  input wire clk_i,
  input wire rst_b_i,
  input wire rx_addr_vld_i,
  input wire [4:0] rx_addr_i,
  input wire [4:0] station_addr_o,
  input wire addr_hit_o,
  input wire line_tick_i,
  input wire slip_b_i,
  input wire [7:0] loopback_control_o,
  input wire line_loopback_out_o,
  input wire payload_loopback_out_o,
  input wire slip_ind_o,
  input wire tx_byte_done_i,
  input wire tx_flag_o,
  input wire tx_yellow_o,
  input wire tx_report_o,
  input wire tx_unsched_o,
  input wire nv_wr_o,
  input wire [4:0] nv_wdata_o,
  input wire user_strap_one_i,
  input wire user_strap_two_i,
  input wire user_strap_three_i,
  input wire user_strap_four_i,
  input wire user_strap_five_i
);
  reg [4:0] flags_q;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) flags_q <= 5'h00;
    else if (!tx_flag_o) flags_q <= 5'h00;
    else if (tx_byte_done_i) flags_q <= flags_q + 5'h01;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_store;
    station_addr_o == $past(nv_wdata_o, 2);
  endsequence
  property p_hit;
    rx_addr_vld_i && rx_addr_i == station_addr_o && rx_addr_i != 5'h1f |=> addr_hit_o;
  endproperty
  a_hit: assert property (p_hit) else $error("own address not answered");
  property p_no31;
    rx_addr_vld_i && rx_addr_i == 5'h1f |=> !addr_hit_o;
  endproperty
  a_no31: assert property (p_no31) else $error("address 31 answered");
  property p_rst;
    $rose(rst_b_i) |-> loopback_control_o == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("loopback register not cleared");
  // readback lags the live register by one cycle, so compare the cycle after the tick
  property p_lloop;
    line_tick_i ##1 loopback_control_o[3] |-> line_loopback_out_o == loopback_control_o[2];
  endproperty
  a_lloop: assert property (p_lloop) else $error("line loop not forced");
  property p_ploop;
    line_tick_i ##1 loopback_control_o[1] |-> payload_loopback_out_o == loopback_control_o[0];
  endproperty
  a_ploop: assert property (p_ploop) else $error("payload loop not forced");
  property p_slip;
    line_tick_i ##1 1'b1 |-> slip_ind_o == (!$past(slip_b_i) && !loopback_control_o[6]);
  endproperty
  a_slip: assert property (p_slip) else $error("slip indication wrong");
  property p_flag;
    $rose(tx_flag_o) |-> !tx_yellow_o;
  endproperty
  a_flag: assert property (p_flag) else $error("yellow kept during flags");
  property p_open;
    $rose(tx_report_o) |-> flags_q == 5'd27;
  endproperty
  a_open: assert property (p_open) else $error("opening flag count wrong");
  property p_uopen;
    $rose(tx_unsched_o) |-> flags_q == 5'd27;
  endproperty
  a_uopen: assert property (p_uopen) else $error("flags before unscheduled message wrong");
  property p_prog;
    nv_wr_o |-> nv_wdata_o == {user_strap_five_i, user_strap_four_i, user_strap_three_i,
      user_strap_two_i, user_strap_one_i} ##2 s_store;
  endproperty
  a_prog: assert property (p_prog) else $error("programmed address wrong");
endmodule
bind fdlc_config fdlc_config_monitor u_mon (.*);

// ==== verification/fdlc_nv_model.sv ====
// nonvolatile station address store beside the configuration block
`timescale 1ns/1ps
module fdlc_nv_model #(
  parameter [4:0] INIT = 5'h00
) (
  input wire clk_i,
  input wire nv_wr_i,
  input wire [4:0] nv_wdata_i,
  output reg [4:0] nv_addr_o
);
  // no reset input on purpose: contents must outlive every reset of the block
  initial nv_addr_o = INIT;
  always @(posedge clk_i) begin
    if (nv_wr_i) begin
      nv_addr_o <= nv_wdata_i;
    end
  end
endmodule

// ==== verification/test_fdlc_config.sv ====
// self-checking bench for the configuration and loopback block
`timescale 1ns/1ps
`define CHK(a, b) chk(8'(a), 8'(b))
module test_fdlc_config;
  reg clk_i = 0, rst_b_i = 0, b8zs = 1, prog = 0, wr_i = 0, vld = 0, tick = 0, al = 1;
  reg ap = 0, slip_b = 1, yreq = 0, rdue = 0, bdone = 0, mdone = 0, um = 0;
  reg [5:0] strap = 6'h3f;
  reg [1:0] sel = 2'h0;
  reg [7:0] wd = 8'h00;
  reg [4:0] ra = 5'h00;
  wire nv_wr, hit, xoff, hw, ar, lo, po, si, ty, tf, tr, tu, eok;
  wire [4:0] nv_wd, nv_addr, st_addr;
  wire [7:0] lbc, stc, sc, idle, rc;
  int num_errors = 0, n_checks = 0, cyc = 0;
  reg [7:0] lb_v [4] = '{8'h0c, 8'h08, 8'h03, 8'h00};
  reg [1:0] lb_e [4] = '{2'b10, 2'b00, 2'b11, 2'b10};
  fdlc_config #(.PROG_HOLD_CYC(25'd16)) DUT (
    .clk_i, .rst_b_i, .user_strap_one_i(strap[0]), .user_strap_two_i(strap[1]),
    .user_strap_three_i(strap[2]), .user_strap_four_i(strap[3]), .user_strap_five_i(strap[4]),
    .user_strap_six_i(strap[5]), .line_code_strap_i(b8zs), .prog_addr_sel_i(prog),
    .nv_addr_i(nv_addr), .reg_wr_i(wr_i), .reg_sel_i(sel), .reg_wdata_i(wd),
    .rx_addr_vld_i(vld), .rx_addr_i(ra), .line_tick_i(tick), .auto_line_loop_i(al),
    .auto_payload_loop_i(ap), .slip_b_i(slip_b), .yellow_req_i(yreq), .report_due_i(rdue),
    .unsched_msg_i(um), .tx_byte_done_i(bdone), .msg_done_i(mdone), .nv_wr_o(nv_wr),
    .nv_wdata_o(nv_wd), .station_addr_o(st_addr), .addr_hit_o(hit), .extra_bit_off_o(xoff),
    .loopback_control_o(lbc), .station_control_o(stc), .strap_config_o(sc),
    .report_config_o(rc), .hw_mode_o(hw), .auto_run_o(ar), .idle_code_o(idle),
    .line_loopback_out_o(lo), .payload_loopback_out_o(po), .slip_ind_o(si),
    .enh_cfg_resp_ok_o(eok), .tx_yellow_o(ty), .tx_flag_o(tf), .tx_report_o(tr),
    .tx_unsched_o(tu));
  fdlc_nv_model u_nv (.clk_i, .nv_wr_i(nv_wr), .nv_wdata_i(nv_wd), .nv_addr_o(nv_addr));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      report_and_stop;
    end
  end
  task chk(input [7:0] g, input [7:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task cy(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // straps only count at reset and at the end of programming, so every user strap change goes through here; the line code strap is set before the call
  task boot(input [5:0] s, input p);
    strap = s;
    prog = p;
    rst_b_i = 0;
    cy(2);
    rst_b_i = 1;
    cy(3);
  endtask
  task wr(input [1:0] s, input [7:0] d);
    sel = s;
    wd = d;
    wr_i = 1;
    cy(1);
    wr_i = 0;
    cy(2);
  endtask
  task tk;
    tick = 1;
    cy(1);
    tick = 0;
    cy(1);
  endtask
  task rx(input [4:0] a, input e);
    vld = 1;
    ra = a;
    cy(1);
    vld = 0;
    `CHK(hit, e);
    cy(1);
  endtask
  task pulse_done;
    bdone = 1;
    cy(1);
    bdone = 0;
    cy(1);
  endtask
  // closes the message and drops every request before the sequencer can start again
  task end_msg;
    mdone = 1;
    cy(1);
    mdone = 0;
    yreq = 0;
    rdue = 0;
    um = 0;
  endtask
  task prog_addr(input [4:0] a);
    boot({1'b1, a}, 1);
    for (int k = 0; k < 40 && nv_wr !== 1'b1; k++) cy(1);
    `CHK(nv_wd, a);
    cy(3);
    `CHK(st_addr, a);
    boot({1'b1, a}, 0);
    `CHK(st_addr, a);
  endtask
  initial begin
    boot(6'h3f, 0);
    `CHK(lbc, 8'h00);
    `CHK(st_addr, 5'h00);
    `CHK(hw, 1'b0);
    `CHK(sc, 8'h07);
    `CHK(idle, 8'hff);
    `CHK(stc, 8'h00);
    `CHK(rc, 8'h00);
    rx(5'h00, 1);
    rx(5'h05, 0);
    $display("test straps and address done");
    for (int i = 0; i < 4; i++) begin
      wr(2'h0, lb_v[i]);
      tk;
      `CHK({lo, po}, lb_e[i]);
    end
    wr(2'h0, 8'hff);
    `CHK(lbc, 8'h6f);
    `CHK(eok, 1'b1);
    slip_b = 0;
    tk;
    `CHK(si, 1'b0);
    wr(2'h0, 8'h00);
    tk;
    `CHK(si, 1'b1);
    `CHK(eok, 1'b0);
    slip_b = 1;
    $display("test loopback and slip done");
    yreq = 1;
    rdue = 1;
    cy(3);
    `CHK({tf, ty}, 2'b01);
    wr(2'h0, 8'h20);
    for (int k = 0; k < 10 && tf !== 1'b1; k++) cy(1);
    `CHK({tf, ty}, 2'b10);
    repeat (26) pulse_done;
    `CHK(tr, 1'b0);
    pulse_done;
    `CHK(tr, 1'b1);
    end_msg;
    $display("test yellow interrupt done");
    b8zs = 0;
    boot(6'h2c, 0);
    `CHK({hw, ar}, 2'b11);
    `CHK(sc, 8'h06);
    `CHK(stc, 8'h03);
    `CHK(rc, 8'h03);
    `CHK(idle, 8'h7e);
    wr(2'h1, 8'h00);
    `CHK(idle, 8'hff);
    $display("test hardware mode done");
    boot(6'h37, 0);
    `CHK(sc, 8'h04);
    yreq = 1;
    rdue = 1;
    um = 1;
    wr(2'h0, 8'h20);
    `CHK({tf, ty}, 2'b10);
    repeat (27) pulse_done;
    `CHK({tr, tu}, 2'b01);
    end_msg;
    $display("test unscheduled override done");
    prog_addr(5'h1e);
    rx(5'h1e, 1);
    `CHK(xoff, 1'b0);
    prog_addr(5'h1f);
    `CHK(xoff, 1'b1);
    rx(5'h1f, 0);
    $display("test address programming done");
    report_and_stop;
  end
endmodule
